// >>> src/scsc_map.svh
`ifndef SCSC_MAP_SVH
`define SCSC_MAP_SVH
// ----------------------------------------------------------------------
// Command word layout
// ----------------------------------------------------------------------
`define SCSC_WORD_W      8
`define SCSC_SUP_LSB     0
`define SCSC_SEL_BIT     2
`define SCSC_ROUTE_LSB   3
`define SCSC_CLK_LSB     5
`define SCSC_CMD_RESET   8'h00
// Idle levels of the synchronised pins, in synchroniser bit order
`define SCSC_SYNC_IDLE   12'hcbd
// ----------------------------------------------------------------------
// Status word layout
// ----------------------------------------------------------------------
`define SCSC_ST_FAULT    4
`define SCSC_ST_ATR      5
`define SCSC_ST_READY    6
`define SCSC_ST_PRESENT  7
// ----------------------------------------------------------------------
// Undervoltage threshold, millivolts (analog comparator outside)
// ----------------------------------------------------------------------
`define SCSC_UV_MV       1230
`endif

// >>> src/scsc_pkg.sv
package scsc_pkg;
  // Card supply codes
  typedef enum logic [1:0] {
    SUP_OFF = 2'h0,
    SUP_1V8 = 2'h1,
    SUP_3V  = 2'h2,
    SUP_5V  = 2'h3
  } scsc_sup_t;
  // Host data line routing
  typedef enum logic [1:0] {
    RT_NONE = 2'h0,
    RT_C4   = 2'h1,
    RT_C8   = 2'h2,
    RT_IO   = 2'h3
  } scsc_route_t;
  // Card clock modes
  typedef enum logic [2:0] {
    CK_SYNC  = 3'h0,
    CK_BIDIR = 3'h1,
    CK_STOPL = 3'h2,
    CK_STOPH = 3'h3,
    CK_DIV1  = 3'h4,
    CK_DIV2  = 3'h5,
    CK_DIV4  = 3'h6,
    CK_DIV8  = 3'h7
  } scsc_ckmode_t;
  // Command word as loaded
  typedef struct packed {
    scsc_ckmode_t ckmode;
    scsc_route_t  route;
    logic         sel;
    scsc_sup_t    sup;
  } scsc_cmd_t;
  // Card contact drive group
  typedef struct packed {
    logic rst;
    logic clk;
    logic clk_oe;
    logic io;
    logic io_oe;
    logic c4;
    logic c8;
  } scsc_card_t;
endpackage : scsc_pkg

// >>> src/scsc_top.sv
// Operation
// - Each shift clock rising edge with load strobe high shifts one serial input bit into the shift register.
// - Status bits leave on the serial output, one per shift clock, while commands enter.
// - Load strobe falling edge copies shift register into command register, taking effect.
// - Load strobe rising edge captures card status into the shift register.
// - Devices chain serial output to serial input, sharing shift clock and load strobe.
// - Selected card reset contact follows reset input.
// - Deselected card reset contact holds its value from deselection.
// - Synchronous mode with card selected: card clock follows sync clock input.
// - Synchronous mode deselected: card clock holds its value from deselection.
// - Bidirectional mode with card selected: a low on sync clock or card clock passes across.
// - Asynchronous divide modes drive card clock with free clock divided 1, 2, 4, 8.
// - Clock-stop modes hold card clock low or high as commanded.
// - Fault output is open drain, the inverse of status bit four.
// - Undervoltage sense starts card deactivation automatically.
// - Card supply set to 0V, 1.8V, 3V or 5V from supply field.
// - Selected card with I/O routed links card I/O both ways to host data.
// - Deselected card I/O returns to idle high.
// - With no contact routed, host data line is released.
// - With card selected, routed C4 or C8 follows host data one way; otherwise holds last value.
// - Card detect input senses card presence.
// - Word is eight bits, bit seven shifted first.
// - Bits 1:0 pick supply: off, 1.8V, 3V, 5V.
// - Bits 7:5 pick clock mode from synchronous to divide by eight.
// - Bits 4:3 route host data: none, C4, C8, card I/O.
`timescale 1ns/1ns
`default_nettype none
`include "scsc_map.svh"

module scsc_top
  import scsc_pkg::*;
(
  // Clock and reset
  input  wire logic       MCLK_I,
  input  wire logic       RESETN_I,
  // Serial control port
  input  wire logic       SCLK_I,
  input  wire logic       LOAD_STROBE_N_I,
  input  wire logic       DIN_I,
  output var  logic       DOUT_O,
  // Host side card signals
  input  wire logic       RESET_IN_I,
  input  wire logic       SYNC_CLOCK_IN_I,
  output var  logic       SYNC_CLOCK_O,
  output var  logic       SYNC_CLOCK_OE_O,
  input  wire logic       FREE_CLOCK_IN_I,
  input  wire logic       DATA_I,
  output var  logic       DATA_O,
  output var  logic       DATA_OE_O,
  // Card contacts
  output var  logic       CARD_RST_O,
  input  wire logic       CARD_CLK_I,
  output var  logic       CARD_CLK_O,
  output var  logic       CARD_CLK_OE_O,
  input  wire logic       CARD_IO_I,
  output var  logic       CARD_IO_O,
  output var  logic       CARD_IO_OE_O,
  output var  logic       CARD_C4_O,
  output var  logic       CARD_C8_O,
  input  wire logic       CARD_DETECT_N_I,
  // Supply and supervision
  output var  logic [1:0] SUPPLY_SEL_O,
  input  wire logic       SUPPLY_READY_I,
  input  wire logic       ELEC_FAULT_I,
  input  wire logic       ATR_FAULT_I,
  input  wire logic       UNDERVOLTAGE_SENSE_N_I,
  output var  logic       FAULT_FLAG_N_O,
  output var  logic       FAULT_FLAG_N_OE_O
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  localparam int NS = 12;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] meta_ff;
  logic [NS-1:0] sync_ff;
  assign raw_in = {SCLK_I, LOAD_STROBE_N_I, DIN_I, RESET_IN_I, SYNC_CLOCK_IN_I,
                   FREE_CLOCK_IN_I, DATA_I, CARD_CLK_I, CARD_IO_I, CARD_DETECT_N_I,
                   ELEC_FAULT_I, UNDERVOLTAGE_SENSE_N_I};

  // Two stages for each of the twelve pins in raw_in; first stage feeds only the second.
  // Reset to idle levels so no false edge or fault follows reset.
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      meta_ff <= `SCSC_SYNC_IDLE;
      sync_ff <= `SCSC_SYNC_IDLE;
    end else begin
      meta_ff <= raw_in;
      sync_ff <= meta_ff;
    end
  end

  logic s_sclk, s_ld_n, s_din, s_rin, s_sync, s_free, s_data, s_cclk, s_cio;
  logic s_det_n, s_efault, s_uv_n;
  assign {s_sclk, s_ld_n, s_din, s_rin, s_sync, s_free, s_data, s_cclk, s_cio,
          s_det_n, s_efault, s_uv_n} = sync_ff;

  // Slow-changing status inputs come from on-chip logic, same clock
  logic atr_fault;
  logic sup_ready;
  assign atr_fault = ATR_FAULT_I;
  assign sup_ready = SUPPLY_READY_I;

  // ----------------------------------------------------------------------
  // Edge detection on synchronised pins
  // ----------------------------------------------------------------------
  logic sclk_d_ff, ld_d_ff, free_d_ff;
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      sclk_d_ff <= 1'b1;
      ld_d_ff   <= 1'b1;
      free_d_ff <= 1'b0;
    end else begin
      sclk_d_ff <= s_sclk;
      ld_d_ff   <= s_ld_n;
      free_d_ff <= s_free;
    end
  end

  logic sclk_rise, ld_fall, ld_rise, free_rise;
  assign sclk_rise = s_sclk & ~sclk_d_ff;
  assign ld_fall   = ~s_ld_n & ld_d_ff;
  assign ld_rise   = s_ld_n & ~ld_d_ff;
  assign free_rise = s_free & ~free_d_ff;

  // ----------------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------------
  logic [`SCSC_WORD_W-1:0] status;
  always_comb begin
    status = 8'h00;
    status[`SCSC_ST_FAULT]   = s_efault;
    status[`SCSC_ST_ATR]     = atr_fault;
    status[`SCSC_ST_READY]   = sup_ready;
    status[`SCSC_ST_PRESENT] = ~s_det_n;    // switch closes to ground
  end

  // ----------------------------------------------------------------------
  // Shift register and serial output
  // ----------------------------------------------------------------------
  // The host raises SCLK while the strobe is low, but shifting is gated off
  // then, so the shift and the capture never meet; capture is given priority anyway.
  logic [`SCSC_WORD_W-1:0] shift_ff;
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      shift_ff <= 8'h00;
    end else if (ld_rise) begin
      shift_ff <= status;
    end else if (sclk_rise && s_ld_n) begin
      shift_ff <= {shift_ff[`SCSC_WORD_W-2:0], s_din};
    end
  end

  // Serial output is the MSB, ready for the next stage in a chain
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      DOUT_O <= 1'b0;
    end else begin
      DOUT_O <= shift_ff[`SCSC_WORD_W-1];
    end
  end

  // ----------------------------------------------------------------------
  // Command register and forced shutdown
  // ----------------------------------------------------------------------
  scsc_cmd_t cmd_ff;
  logic      shut_ff;
  logic      uv_d_ff;
  logic      fault_d_ff;
  logic      deact_evt;
  assign deact_evt = (~s_uv_n & uv_d_ff) | (s_efault & ~fault_d_ff);

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      cmd_ff <= scsc_cmd_t'(`SCSC_CMD_RESET);
    end else if (ld_fall) begin
      cmd_ff <= scsc_cmd_t'(shift_ff);
    end
  end

  // Deactivation latch; a new event wins over a fresh load
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      shut_ff    <= 1'b0;
      uv_d_ff    <= 1'b1;
      fault_d_ff <= 1'b0;
    end else begin
      uv_d_ff    <= s_uv_n;
      fault_d_ff <= s_efault;
      if (deact_evt || !s_uv_n) begin
        shut_ff <= 1'b1;
      end else if (ld_fall) begin
        shut_ff <= 1'b0;
      end
    end
  end

  // Effective settings
  logic        sel;
  scsc_route_t route;
  assign sel   = cmd_ff.sel & ~shut_ff & (cmd_ff.sup != SUP_OFF);
  assign route = cmd_ff.route;

  // Supply selection
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      SUPPLY_SEL_O <= SUP_OFF;
    end else begin
      SUPPLY_SEL_O <= shut_ff ? SUP_OFF : cmd_ff.sup;
    end
  end

  // ----------------------------------------------------------------------
  // Asynchronous clock divider
  // ----------------------------------------------------------------------
  logic [2:0] div_ff;
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      div_ff <= 3'h0;
    end else if (free_rise) begin
      div_ff <= div_ff + 3'h1;
    end
  end

  function automatic logic div_clk(input scsc_ckmode_t m, input logic f,
                                   input logic [2:0] d);
    case (m)
      CK_DIV1: div_clk = f;
      CK_DIV2: div_clk = d[0];
      CK_DIV4: div_clk = d[1];
      CK_DIV8: div_clk = d[2];
      CK_STOPH: div_clk = 1'b1;
      default: div_clk = 1'b0;
    endcase
  endfunction : div_clk

  // ----------------------------------------------------------------------
  // Card contact drive
  // ----------------------------------------------------------------------
  scsc_card_t card_ff;
  scsc_card_t nxt_card;
  always_comb begin
    nxt_card = card_ff;
    nxt_card.clk_oe = 1'b1;
    if (sel) begin
      nxt_card.rst = s_rin;
    end                                                   // holds
    case (cmd_ff.ckmode)
      CK_SYNC: begin
        if (sel) nxt_card.clk = s_sync;
      end
      CK_BIDIR: begin
        nxt_card.clk    = 1'b0;
        nxt_card.clk_oe = sel & ~s_sync & ~SYNC_CLOCK_OE_O;
      end
      CK_STOPL, CK_STOPH: nxt_card.clk = div_clk(cmd_ff.ckmode, s_free, div_ff);
      default: nxt_card.clk = div_clk(cmd_ff.ckmode, s_free, div_ff);
    endcase
    // Card I/O is open drain with idle high
    nxt_card.io    = 1'b0;
    nxt_card.io_oe = sel && route == RT_IO && !s_data && !DATA_OE_O;
    if (sel && route == RT_C4) nxt_card.c4 = s_data;
    if (sel && route == RT_C8) nxt_card.c8 = s_data;
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      card_ff <= '0;
    end else begin
      card_ff <= nxt_card;
    end
  end

  assign CARD_RST_O    = card_ff.rst;
  assign CARD_CLK_O    = card_ff.clk;
  assign CARD_CLK_OE_O = card_ff.clk_oe;
  assign CARD_IO_O     = card_ff.io;
  assign CARD_IO_OE_O  = card_ff.io_oe;
  assign CARD_C4_O     = card_ff.c4;
  assign CARD_C8_O     = card_ff.c8;

  // ----------------------------------------------------------------------
  // Host side drives
  // ----------------------------------------------------------------------
  // Echoing a low we drive ourselves would latch the pair low, so
  // each side only passes a low it did not drive
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      DATA_O          <= 1'b0;
      DATA_OE_O       <= 1'b0;
      SYNC_CLOCK_O    <= 1'b0;
      SYNC_CLOCK_OE_O <= 1'b0;
    end else begin
      DATA_O          <= 1'b0;
      DATA_OE_O       <= sel && route == RT_IO && !s_cio && !card_ff.io_oe;
      SYNC_CLOCK_O    <= 1'b0;
      SYNC_CLOCK_OE_O <= sel && cmd_ff.ckmode == CK_BIDIR && !s_cclk
                         && !card_ff.clk_oe;
    end
  end

  // Fault pin pulls low while an electrical fault is reported
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      FAULT_FLAG_N_O    <= 1'b0;
      FAULT_FLAG_N_OE_O <= 1'b0;
    end else begin
      FAULT_FLAG_N_O    <= 1'b0;
      FAULT_FLAG_N_OE_O <= status[`SCSC_ST_FAULT];
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_LOAD_CMD: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    ld_fall |=> cmd_ff == scsc_cmd_t'($past(shift_ff)))
    else $error("command not loaded on strobe fall");
  AST_CAPTURE: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    ld_rise |=> shift_ff == $past(status))
    else $error("status not captured on strobe rise");
  AST_SHIFT: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (sclk_rise && s_ld_n && !ld_rise) |=> shift_ff[0] == $past(s_din))
    else $error("serial bit not shifted in");
  AST_DOUT: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    ##1 DOUT_O == $past(shift_ff[7]))
    else $error("serial output not msb");
  AST_RST_HOLD: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (!sel && $past(!sel)) |=> $stable(CARD_RST_O))
    else $error("reset contact moved while deselected");
  AST_SHUTDOWN: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    deact_evt |=> ##1 SUPPLY_SEL_O == SUP_OFF)
    else $error("supply not forced off");
  AST_FAULT_PIN: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    s_efault |=> FAULT_FLAG_N_OE_O && !FAULT_FLAG_N_O)
    else $error("fault pin not pulled low");
  AST_DATA_REL: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (route == RT_NONE) |=> !DATA_OE_O)
    else $error("data line driven with no route");
  AST_STOP: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (cmd_ff.ckmode == CK_STOPH) |=> CARD_CLK_O)
    else $error("clock not held high");

endmodule : scsc_top
`default_nettype wire

// >>> tb/scsc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module scsc_host_model (
  // Clock
  input  wire logic clk_i,
  // Serial port pins
  output var  logic sclk_o,
  output var  logic load_strobe_n_o,
  output var  logic din_o,
  input  wire logic dout_i
);
  // Idle with shift clock and strobe high
  initial begin
    sclk_o = 1'b1;
    load_strobe_n_o = 1'b1;
    din_o = 1'b0;
  end
  // Six cycles per level keeps every pin pulse above the sampler's minimum
  task automatic hold_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : hold_cyc
  // One word, MSB first; status bit read before each rise, chain-ready
  task automatic xfer(input logic [7:0] cmd, output logic [7:0] st);
    for (int i = 7; i >= 0; i--) begin
      sclk_o <= 1'b0;
      din_o  <= cmd[i];
      hold_cyc(6);
      st[i] = dout_i;
      sclk_o <= 1'b1;
      hold_cyc(6);
    end
    // Shift clock low before the strobe falls, high again before it rises
    sclk_o <= 1'b0;
    hold_cyc(6);
    load_strobe_n_o <= 1'b0;
    hold_cyc(6);
    sclk_o <= 1'b1;
    hold_cyc(6);
    load_strobe_n_o <= 1'b1;
    hold_cyc(6);
  endtask : xfer
endmodule : scsc_host_model
`default_nettype wire

// >>> tb/tb_scsc_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_scsc_top;
  import scsc_pkg::*;
  // ------------------------------------------------------------------
  // Pins and bench state
  // ------------------------------------------------------------------
  logic        mclk = 1'b0, resetn = 1'b0, sclk, ld_n, din, dout;
  logic        rst_in = 1'b0, sync_in = 1'b1, free_clk = 1'b0, host_data = 1'b1;
  logic        io_drv = 1'b1, ck_drv = 1'b1, det_n = 1'b1, rdy = 1'b0;
  logic        elec = 1'b0, atr = 1'b0, uv_n = 1'b1, r, s, prev;
  logic        sync_o, sync_oe, data_o, data_oe, crst, cclk_o, cclk_oe;
  logic        cio_o, cio_oe, c4, c8, ff_n, ff_oe;
  logic [1:0]  sup;
  logic [7:0]  st;
  logic [31:0] lfsr = 32'h293b;
  int          n_fail = 0, cmp_count = 0, cyc = 0, cnt;
  // Open-drain lines with pull-ups: any low wins
  wire         data_w = ~(data_oe & ~data_o) & host_data;
  wire         sync_w = ~(sync_oe & ~sync_o) & sync_in;
  wire         cio_w  = ~(cio_oe & ~cio_o) & io_drv;
  wire         cclk_w = ~(cclk_oe & ~cclk_o) & ck_drv;
  always #4 mclk = ~mclk;
  // Free clock of sixteen cycles, well below a quarter of the system clock
  always begin
    repeat (8) @(posedge mclk);
    free_clk <= ~free_clk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      finish_test();
    end
  end
  scsc_host_model host (.clk_i(mclk), .sclk_o(sclk), .load_strobe_n_o(ld_n),
    .din_o(din), .dout_i(dout));
  scsc_top dut (.MCLK_I(mclk), .RESETN_I(resetn), .SCLK_I(sclk), .LOAD_STROBE_N_I(ld_n),
    .DIN_I(din), .DOUT_O(dout), .RESET_IN_I(rst_in), .SYNC_CLOCK_IN_I(sync_w),
    .SYNC_CLOCK_O(sync_o), .SYNC_CLOCK_OE_O(sync_oe), .FREE_CLOCK_IN_I(free_clk),
    .DATA_I(data_w), .DATA_O(data_o), .DATA_OE_O(data_oe), .CARD_RST_O(crst),
    .CARD_CLK_I(cclk_w), .CARD_CLK_O(cclk_o), .CARD_CLK_OE_O(cclk_oe), .CARD_IO_I(cio_w),
    .CARD_IO_O(cio_o), .CARD_IO_OE_O(cio_oe), .CARD_C4_O(c4), .CARD_C8_O(c8),
    .CARD_DETECT_N_I(det_n), .SUPPLY_SEL_O(sup), .SUPPLY_READY_I(rdy),
    .ELEC_FAULT_I(elec), .ATR_FAULT_I(atr), .UNDERVOLTAGE_SENSE_N_I(uv_n),
    .FAULT_FLAG_N_O(ff_n), .FAULT_FLAG_N_OE_O(ff_oe));
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
  endtask : w
  task automatic rnd;
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
  endtask : rnd
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Status word: present, supply ready, ATR fault, electrical fault
  function automatic logic [7:0] exp_status(input logic dn, rd, at);
    return {~dn, rd, at, 1'b0, 4'h0};
  endfunction : exp_status
  // Card clock rises in 512 cycles: 32 free clock rises, divided down
  function automatic int exp_rises(input scsc_ckmode_t m);
    return (m < CK_DIV1) ? 0 : 32 >> (m - CK_DIV1);
  endfunction : exp_rises
  task automatic cmd(input scsc_ckmode_t m, input scsc_route_t rt, input logic sl,
                     input scsc_sup_t sp);
    host.xfer({m, rt, sl, sp}, st);
  endtask : cmd
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    w(3);
    resetn <= 1'b1;
    w(4);
    chk("supply after reset", 8'h00, {6'h0, sup});
    chk("data oe after reset", 8'h00, {7'h0, data_oe});
    // Status capture on strobe rise, shifted out MSB first
    for (int k = 0; k < 4; k++) begin
      rnd();
      det_n <= k[0];
      rdy <= k[1];
      atr <= lfsr[0];
      w(2);
      host.xfer(8'h00, st);
      host.xfer(8'h00, st);
      chk("status", exp_status(k[0], k[1], atr), st);
    end
    // Every supply code takes effect on load
    for (int k = 0; k < 4; k++) begin
      cmd(CK_SYNC, RT_NONE, 1'b1, scsc_sup_t'(k));
      chk("supply", 8'(k), {6'h0, sup});
    end
    // Selected: reset and clock follow the host
    repeat (8) begin
      rnd();
      rst_in <= lfsr[0];
      sync_in <= lfsr[1];
      w(6);
      chk("card rst", {7'h0, rst_in}, {7'h0, crst});
      chk("card clk", {7'h0, sync_in}, {7'h0, cclk_o});
    end
    r = rst_in;
    s = sync_in;
    cmd(CK_SYNC, RT_IO, 1'b0, SUP_5V);
    repeat (4) begin
      rnd();
      rst_in <= lfsr[0];
      sync_in <= lfsr[1];
      w(6);
      chk("held rst", {7'h0, r}, {7'h0, crst});
      chk("held clk", {7'h0, s}, {7'h0, cclk_o});
      chk("idle io", 8'h00, {7'h0, cio_oe});
    end
    sync_in <= 1'b1;
    // Stop and divide modes
    for (int m = 2; m < 8; m++) begin
      cmd(scsc_ckmode_t'(m), RT_NONE, 1'b1, SUP_3V);
      cnt = 0;
      prev = cclk_o;
      repeat (512) begin
        @(posedge mclk);
        if (cclk_o && !prev) cnt++;
        prev = cclk_o;
      end
      chk("clk rises", 8'h01, {7'h0, (cnt - exp_rises(scsc_ckmode_t'(m))) inside {[-1:1]}});
      if (m < 4) chk("stop level", 8'(m - 2), {7'h0, cclk_o});
    end
    // Bidirectional clock: a low crosses either way
    cmd(CK_BIDIR, RT_NONE, 1'b1, SUP_3V);
    sync_in <= 1'b0;
    w(6);
    chk("bidir to card", 8'h00, {7'h0, cclk_w});
    sync_in <= 1'b1;
    w(6);
    ck_drv <= 1'b0;
    w(6);
    chk("bidir to host", 8'h00, {7'h0, sync_w});
    ck_drv <= 1'b1;
    // Routing of the host data line
    cmd(CK_STOPL, RT_C4, 1'b1, SUP_3V);
    repeat (4) begin
      rnd();
      host_data <= lfsr[0];
      w(6);
      chk("c4", {7'h0, host_data}, {7'h0, c4});
    end
    r = c4;
    cmd(CK_STOPL, RT_C8, 1'b1, SUP_3V);
    repeat (4) begin
      rnd();
      host_data <= lfsr[0];
      w(6);
      chk("c8", {7'h0, host_data}, {7'h0, c8});
      chk("c4 held", {7'h0, r}, {7'h0, c4});
    end
    host_data <= 1'b1;
    cmd(CK_STOPL, RT_IO, 1'b1, SUP_3V);
    host_data <= 1'b0;
    w(6);
    chk("io from host", 8'h00, {7'h0, cio_w});
    host_data <= 1'b1;
    w(6);
    io_drv <= 1'b0;
    w(6);
    chk("io to host", 8'h00, {7'h0, data_w});
    cmd(CK_STOPL, RT_NONE, 1'b1, SUP_3V);
    chk("data released", 8'h00, {7'h0, data_oe});
    io_drv <= 1'b1;
    // Electrical fault and undervoltage force shutdown until the next load
    elec <= 1'b1;
    w(6);
    chk("fault flag", 8'h02, {6'h0, ff_oe, ff_n});
    chk("fault shutdown", 8'h00, {6'h0, sup});
    elec <= 1'b0;
    cmd(CK_SYNC, RT_NONE, 1'b1, SUP_5V);
    chk("reloaded", 8'h03, {6'h0, sup});
    uv_n <= 1'b0;
    w(6);
    chk("uv shutdown", 8'h00, {6'h0, sup});
    uv_n <= 1'b1;
    finish_test();
  end
endmodule : tb_scsc_top
`default_nettype wire
